// ---- design/ssem_pkg.sv ----
// package: constants and types for the supply supervisor event mask block
// Summary of operation
// - re-enabled comparator events are masked for a settling interval per mode
// - full-performance mask lasts 2 us; normal mode uses its own longer mask
// - any unmasked high- or low-side detection sets that side's fault flag
// - detection also raises power-on reset when that side's reset enable is set
// - general-purpose pins tri-state while fault flags set, until comparators settle
// - keep bit clear switches comparators off in deep sleep, on again when active
// - wakeup with keep clear and full performance may falsely set fault flags
// - after reset, supervisors re-enable but no settling mask starts
package ssem_pkg;
    localparam int unsigned CLK_MHZ        = 125;
    localparam int unsigned MASK_FP_NS     = 2000;
    localparam int unsigned MASK_NORM_US   = 150;
    localparam int unsigned MASK_FP_CYC    = MASK_FP_NS * CLK_MHZ / 1000;
    localparam int unsigned MASK_NORM_CYC  = MASK_NORM_US * CLK_MHZ;
    localparam int unsigned CNT_W          = 16;
    localparam int unsigned NSIDE          = 2;
    localparam int unsigned SIDE_HIGH      = 0;
    localparam int unsigned SIDE_LOW       = 1;
    // register map, byte offsets
    localparam logic [7:0] ADDR_CTRL       = 8'h00;
    localparam logic [7:0] ADDR_STATUS     = 8'h04;
    localparam logic [7:0] ADDR_MASK       = 8'h08;
    localparam logic [7:0] ADDR_STATE      = 8'h0c;
    // ctrl fields, per side s: bit base s*4
    localparam int unsigned CTRL_EN        = 0;
    localparam int unsigned CTRL_FP        = 1;
    localparam int unsigned CTRL_RST_EN    = 2;
    localparam int unsigned CTRL_KEEP      = 3;
    localparam int unsigned CTRL_STRIDE    = 4;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0011;
    localparam logic [31:0] MASK_RESET     = 32'h0000_0000;
    typedef struct packed {
        logic enable;
        logic full_performance;
        logic reset_enable;
        logic lowpower_keep;
    } ssem_side_cfg_t;
    typedef struct packed {
        logic [31:0] adr;
        logic [31:0] dat;
        logic [3:0]  sel;
        logic        we;
        logic        cyc;
        logic        stb;
    } ssem_wb_req_t;
endpackage : ssem_pkg

// ---- design/ssem_top.sv ----
// module: supply supervisor event mask with wishbone registers
`timescale 1ns/100ps
module ssem_top (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire ssem_pkg::ssem_wb_req_t  wb_req_i,
    output logic [31:0]                  wb_dat_o,
    output logic                         wb_ack_o,
    input  wire logic                    deep_sleep_modes_i,
    input  wire logic                    high_side_supervisor_i,
    input  wire logic                    low_side_supervisor_i,
    output logic                         comparator_on_o,
    output logic                         por_request_o,
    output logic                         gpio_tristate_o,
    output logic                         irq_o
);
    import ssem_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [31:0]          ctrl_reg,   ctrl_next;
    logic [NSIDE-1:0]     flag_reg,   flag_next;
    logic [NSIDE-1:0]     imask_reg,  imask_next;
    logic                 ack_reg,    ack_next;
    logic [31:0]          dat_reg,    dat_next;
    logic                 por_reg,    por_next;
    logic                 boot_reg,   boot_next;
    logic [NSIDE-1:0]     cmp_on_reg, cmp_on_next;
    logic [CNT_W-1:0]     cnt_reg   [NSIDE];
    logic [CNT_W-1:0]     cnt_next  [NSIDE];
    logic [NSIDE-1:0]     settled;
    logic [NSIDE-1:0]     detect;
    logic [NSIDE-1:0]     cmp_in;
    logic [NSIDE-1:0]     want_on;
    logic                 wr_stb;
    logic                 rd_stb;
    ssem_side_cfg_t       cfg [NSIDE];

    assign cmp_in[SIDE_HIGH] = high_side_supervisor_i;
    assign cmp_in[SIDE_LOW]  = low_side_supervisor_i;
    // a write lands on the edge at which the master samples ack high
    assign wr_stb = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & ack_reg;
    assign rd_stb = wb_req_i.cyc & wb_req_i.stb & ~wb_req_i.we & ~ack_reg;

    ////////////////////////////////////////////////////////////////////////
    // per-side comparator power, mask counter and detection
    for (genvar s = 0; s < NSIDE; s++)
    begin : g_side
        // fields picked by the ctrl bit map, not by the struct layout
        assign cfg[s] = '{
            enable:           ctrl_reg[s*CTRL_STRIDE + CTRL_EN],
            full_performance: ctrl_reg[s*CTRL_STRIDE + CTRL_FP],
            reset_enable:     ctrl_reg[s*CTRL_STRIDE + CTRL_RST_EN],
            lowpower_keep:    ctrl_reg[s*CTRL_STRIDE + CTRL_KEEP]
        };
        // keep clear powers the comparator down while sleeping
        assign want_on[s] = cfg[s].enable &
            (cfg[s].lowpower_keep | ~deep_sleep_modes_i);
        assign settled[s] = (cnt_reg[s] == '0);
        // counter running means the comparator output is not trusted
        assign detect[s] = cmp_on_reg[s] & settled[s] & cmp_in[s];

        always_comb
        begin
            cnt_next[s] = cnt_reg[s];
            if (!want_on[s])
            begin
                cnt_next[s] = '0;
            end
            // first turn-on after reset is not masked
            else if (!cmp_on_reg[s] && !boot_reg)
            begin
                // fp mask is short; comparator may not settle in time
                cnt_next[s] = cfg[s].full_performance
                    ? CNT_W'(MASK_FP_CYC) : CNT_W'(MASK_NORM_CYC);
            end
            else if (!settled[s])
            begin
                cnt_next[s] = cnt_reg[s] - CNT_W'(1);
            end
        end

        always_ff @(posedge clk_i)
        begin
            if (rst_i)
            begin
                // reset turns comparators on with no mask armed
                cnt_reg[s] <= '0;
            end
            else
            begin
                cnt_reg[s] <= cnt_next[s];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers, flags, reset request
    always_comb
    begin
        ctrl_next   = ctrl_reg;
        flag_next   = flag_reg;
        imask_next  = imask_reg;
        dat_next    = dat_reg;
        ack_next    = wb_req_i.cyc & wb_req_i.stb & ~ack_reg;
        cmp_on_next = want_on;
        por_next    = 1'b0;
        boot_next   = 1'b0;
        if (wr_stb && wb_req_i.sel[0])
        begin
            unique case (wb_req_i.adr[7:0])
                ADDR_CTRL:   ctrl_next[7:0] = wb_req_i.dat[7:0];
                ADDR_STATUS: flag_next = flag_reg & ~wb_req_i.dat[NSIDE-1:0];
                ADDR_MASK:   imask_next = wb_req_i.dat[NSIDE-1:0];
                default:     ;
            endcase
        end
        // set beats a clear in the same cycle
        flag_next = flag_next | detect;
        for (int i = 0; i < NSIDE; i++)
        begin
            if (detect[i] && cfg[i].reset_enable)
            begin
                por_next = 1'b1;
            end
        end
        if (rd_stb)
        begin
            unique case (wb_req_i.adr[7:0])
                ADDR_CTRL:   dat_next = {24'h0, ctrl_reg[7:0]};
                ADDR_STATUS: dat_next = {30'h0, flag_reg};
                ADDR_MASK:   dat_next = {30'h0, imask_reg};
                ADDR_STATE:  dat_next = {28'h0, settled, cmp_on_reg};
                default:     dat_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_reg   <= CTRL_RESET;
            flag_reg   <= '0;
            imask_reg  <= MASK_RESET[NSIDE-1:0];
            ack_reg    <= 1'b0;
            dat_reg    <= 32'h0;
            por_reg    <= 1'b0;
            boot_reg   <= 1'b1;
            cmp_on_reg <= '0;
        end
        else
        begin
            ctrl_reg   <= ctrl_next;
            flag_reg   <= flag_next;
            imask_reg  <= imask_next;
            ack_reg    <= ack_next;
            dat_reg    <= dat_next;
            por_reg    <= por_next;
            boot_reg   <= boot_next;
            cmp_on_reg <= cmp_on_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign wb_dat_o        = dat_reg;
    assign wb_ack_o        = ack_reg;
    assign comparator_on_o = |cmp_on_reg;
    assign por_request_o   = por_reg;
    // pins float while a flag is set and a comparator still settles
    assign gpio_tristate_o = |flag_reg & ~&(settled | ~cmp_on_reg);
    assign irq_o           = |(flag_reg & imask_reg);

    ////////////////////////////////////////////////////////////////////////
    sequence s_fp_enable;
        !boot_reg && !cmp_on_reg[0] && want_on[0]
        && cfg[0].full_performance;
    endsequence

    a_fp_mask_len: assert property (@(posedge clk_i) disable iff (rst_i)
        s_fp_enable |=> cnt_reg[0] == CNT_W'(MASK_FP_CYC))
        else $error("fp mask length wrong");
    a_norm_mask_len: assert property (@(posedge clk_i) disable iff (rst_i)
        !boot_reg && !cmp_on_reg[1] && want_on[1]
        && !cfg[1].full_performance
        |=> cnt_reg[1] == CNT_W'(MASK_NORM_CYC))
        else $error("normal mask length wrong");
    a_mask_blocks_flag: assert property (@(posedge clk_i)
        disable iff (rst_i)
        !settled[0] && !flag_reg[0] && !(wr_stb && wb_req_i.sel[0])
        |=> !flag_reg[0])
        else $error("flag set while masked");
    a_detect_sets_flag: assert property (@(posedge clk_i)
        disable iff (rst_i) detect[1] |=> flag_reg[1])
        else $error("detection did not set flag");
    a_por_on_detect: assert property (@(posedge clk_i)
        disable iff (rst_i)
        detect[0] && cfg[0].reset_enable |=> por_request_o)
        else $error("no reset request on detection");
    a_no_por_disabled: assert property (@(posedge clk_i)
        disable iff (rst_i)
        !(detect[0] && cfg[0].reset_enable)
        && !(detect[1] && cfg[1].reset_enable) |=> !por_request_o)
        else $error("spurious reset request");
    a_sleep_off: assert property (@(posedge clk_i) disable iff (rst_i)
        deep_sleep_modes_i && !cfg[0].lowpower_keep |=> !cmp_on_reg[0])
        else $error("comparator kept on in sleep");
    a_tristate_flag: assert property (@(posedge clk_i)
        disable iff (rst_i) gpio_tristate_o |-> flag_reg != '0)
        else $error("pins floating without flag");
    a_reset_no_mask: assert property (@(posedge clk_i)
        $fell(rst_i) |=> settled == '1)
        else $error("mask armed after reset");

    ////////////////////////////////////////////////////////////////////////
    sequence s_norm_enable_high;
        !boot_reg && !cmp_on_reg[0] && want_on[0]
        && !cfg[0].full_performance;
    endsequence
    sequence s_sleep_keep_clear;
        deep_sleep_modes_i && cfg[0].enable && !cfg[0].lowpower_keep;
    endsequence
    sequence s_wake_enabled;
        !deep_sleep_modes_i && cfg[0].enable;
    endsequence

    a_norm_mask_high: assert property (@(posedge clk_i)
        disable iff (rst_i)
        s_norm_enable_high |=> cnt_reg[0] == CNT_W'(MASK_NORM_CYC))
        else $error("high side normal mask length wrong");

    a_wake_mask: assert property (@(posedge clk_i)
        disable iff (rst_i)
        s_sleep_keep_clear ##1 s_wake_enabled
        |=> cmp_on_reg[0] && !settled[0])
        else $error("no settling mask after wakeup");

    a_mask_counts_high: assert property (@(posedge clk_i)
        disable iff (rst_i)
        !settled[0] && cmp_on_reg[0] && want_on[0]
        |=> cnt_reg[0] == $past(cnt_reg[0]) - CNT_W'(1))
        else $error("high side mask counter not counting down");

    a_mask_counts_low: assert property (@(posedge clk_i)
        disable iff (rst_i)
        !settled[1] && cmp_on_reg[1] && want_on[1]
        |=> cnt_reg[1] == $past(cnt_reg[1]) - CNT_W'(1))
        else $error("low side mask counter not counting down");

    a_mask_blocks_low: assert property (@(posedge clk_i)
        disable iff (rst_i)
        !settled[1] && !flag_reg[1] |=> !flag_reg[1])
        else $error("low side flag set while masked");

    a_mask_blocks_por: assert property (@(posedge clk_i)
        disable iff (rst_i)
        !settled[0] && !settled[1] |=> !por_request_o)
        else $error("reset request while both sides masked");

    a_detect_sets_high: assert property (@(posedge clk_i)
        disable iff (rst_i) detect[0] |=> flag_reg[0])
        else $error("high side detection did not set flag");

    a_flag_sticky: assert property (@(posedge clk_i)
        disable iff (rst_i)
        flag_reg[0] && !(wr_stb && wb_req_i.sel[0]
        && wb_req_i.adr[7:0] == ADDR_STATUS && wb_req_i.dat[0])
        |=> flag_reg[0])
        else $error("fault flag lost without a clear");

    a_status_clear: assert property (@(posedge clk_i)
        disable iff (rst_i)
        wr_stb && wb_req_i.sel[0] && wb_req_i.adr[7:0] == ADDR_STATUS
        && wb_req_i.dat[1] && !detect[1] |=> !flag_reg[1])
        else $error("write one did not clear low side flag");

    a_no_detect_off: assert property (@(posedge clk_i)
        disable iff (rst_i)
        !cmp_on_reg[1] && !flag_reg[1] |=> !flag_reg[1])
        else $error("flag set by a powered down comparator");

    a_sleep_off_low: assert property (@(posedge clk_i)
        disable iff (rst_i)
        deep_sleep_modes_i && !cfg[1].lowpower_keep |=> !cmp_on_reg[1])
        else $error("low side comparator kept on in sleep");

    a_wake_on_high: assert property (@(posedge clk_i)
        disable iff (rst_i)
        !deep_sleep_modes_i && cfg[0].enable |=> cmp_on_reg[0])
        else $error("comparator not back on when active");

    a_keep_in_sleep: assert property (@(posedge clk_i)
        disable iff (rst_i)
        cfg[0].enable && cfg[0].lowpower_keep |=> cmp_on_reg[0])
        else $error("kept comparator switched off");

    a_pins_float: assert property (@(posedge clk_i)
        disable iff (rst_i)
        flag_reg != '0 && cmp_on_reg[0] && !settled[0] |-> gpio_tristate_o)
        else $error("pins driven while flag set and masked");

    a_pins_release: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (settled | ~cmp_on_reg) == '1 |-> !gpio_tristate_o)
        else $error("pins floating after comparators settled");

    a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    a_read_upper: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |-> wb_dat_o[31:8] == '0)
        else $error("upper read data bits not zero");
endmodule : ssem_top

// ---- testbench/ssem_top_tb.sv ----
// testbench: register, settling mask and deep sleep scenarios
`timescale 1ns/100ps
module ssem_top_tb;
    import ssem_pkg::*;
    logic         clk_i = 1'b0;
    logic         rst_i = 1'b1;
    ssem_wb_req_t req   = '0;
    logic         sleep = 1'b0;
    logic         hi    = 1'b1;
    logic         lo    = 1'b0;
    logic [31:0]  wb_dat_o;
    logic         wb_ack_o;
    logic         cmp_on;
    logic         por;
    logic         float_pins;
    logic         irq_o;
    logic [31:0]  rd;
    int           n;
    int           err_total = 0;
    int           compares  = 0;
    always #4 clk_i = ~clk_i;
    ssem_top u_ssem_top (
        .clk_i                  (clk_i),
        .rst_i                  (rst_i),
        .wb_req_i               (req),
        .wb_dat_o               (wb_dat_o),
        .wb_ack_o               (wb_ack_o),
        .deep_sleep_modes_i     (sleep),
        .high_side_supervisor_i (hi),
        .low_side_supervisor_i  (lo),
        .comparator_on_o        (cmp_on),
        .por_request_o          (por),
        .gpio_tristate_o        (float_pins),
        .irq_o                  (irq_o)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // all tasks start and end in the time step of a rising edge
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d);
        int k;
        k = 0;
        req <= '{adr: {24'h00, a}, dat: d, sel: 4'hf, we: we,
                 cyc: 1'b1, stb: 1'b1};
        do
        begin
            @(posedge clk_i);
            k++;
        end
        while (wb_ack_o !== 1'b1 && k < 20);
        chk("ack", 32'(wb_ack_o), 32'h1);
        if (wb_ack_o !== 1'b1)
            tally_and_finish();
        rd = wb_dat_o;
        req <= '0;
        @(posedge clk_i);
    endtask : wb
    // counts edges while s holds v; a run reaching lim ends the run
    task automatic hold_len(ref logic s, input logic v, input int lim,
                            output int c);
        c = 0;
        while (s === v && c < lim)
        begin
            @(posedge clk_i);
            c++;
        end
        if (c >= lim)
        begin
            err_total++;
            tally_and_finish();
        end
    endtask : hold_len
    ////////////////////////////////////////////////////////////////////////
    task automatic sc_regs();
        wb(1'b0, ADDR_CTRL, 32'h0);
        chk("ctrl", rd, CTRL_RESET);
        wb(1'b0, 8'h20, 32'h0);
        chk("unmapped", rd, 32'h0);
        wb(1'b0, ADDR_STATUS, 32'h0);
        chk("flag after reset", rd, 32'h1);
        wb(1'b0, ADDR_MASK, 32'h0);
        chk("mask", rd, MASK_RESET);
        wb(1'b1, ADDR_MASK, 32'h3);
        chk("irq", 32'(irq_o), 32'h1);
        hi <= 1'b0;
        lo <= 1'b1;
        repeat (3) @(posedge clk_i);
        lo <= 1'b0;
        wb(1'b0, ADDR_STATUS, 32'h0);
        chk("low side flag", rd, 32'h3);
        wb(1'b1, ADDR_STATUS, 32'h3);
        chk("irq cleared", 32'(irq_o), 32'h0);
    endtask : sc_regs
    task automatic sc_full_perf();
        wb(1'b1, ADDR_CTRL, 32'h10);
        hi <= 1'b1;
        wb(1'b1, ADDR_CTRL, 32'h17);
        hold_len(por, 1'b0, 400, n);
        chk("fp mask", 32'(n >= 240 && n <= 260), 32'h1);
        chk("pins settled", 32'(float_pins), 32'h0);
        hi <= 1'b0;
        wb(1'b1, ADDR_CTRL, 32'h11);
        wb(1'b1, ADDR_STATUS, 32'h3);
        wb(1'b0, ADDR_STATUS, 32'h0);
        chk("status clear", rd, 32'h0);
    endtask : sc_full_perf
    task automatic sc_sleep();
        hi <= 1'b1;
        repeat (3) @(posedge clk_i);
        hi <= 1'b0;
        sleep <= 1'b1;
        @(posedge clk_i);
        // raised only once the low side comparator is already off
        lo <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("off in sleep", 32'(cmp_on), 32'h0);
        lo <= 1'b0;
        sleep <= 1'b0;
        hold_len(cmp_on, 1'b0, 10, n);
        // pins float for the whole normal-mode settle after wakeup
        hold_len(float_pins, 1'b1, 20000, n);
        chk("wake mask", 32'(n >= 18740 && n <= 18760), 32'h1);
        wb(1'b0, ADDR_STATUS, 32'h0);
        chk("sleep input ignored", rd, 32'h1);
        wb(1'b1, ADDR_CTRL, 32'h1b);
        sleep <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk("kept in sleep", 32'(cmp_on), 32'h1);
        sleep <= 1'b0;
    endtask : sc_sleep
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        sc_regs();
        sc_full_perf();
        sc_sleep();
        tally_and_finish();
    end
endmodule : ssem_top_tb
